// file: xhbp_pkg.sv
// Purpose: Shared constants and types for host block protection
// Assumes: 8-bit register port, two chip selects
// Notes: Offsets are byte offsets of the register port
package xhbp_pkg;
    // ========================================
    // Register map
    localparam logic [7:0] OFS_CS0 = 8'h13; // Protect reg, chip select 0
    localparam logic [7:0] OFS_CS1 = 8'h14; // Protect reg, chip select 1
    // ========================================
    // Geometry
    localparam int BLOCKS = 16; // Blocks per chip select
    localparam int IDX_W = 4; // Index width
    localparam int ADDR_W = 24; // Memory address width
    localparam int MIN_SHIFT = 14; // 16 KByte block
    localparam logic [2:0] MAX_SIZE_CODE = 3'h6; // 1 MByte block
    // ========================================
    // Reset values
    localparam logic [3:0] IDX_RST = 4'h0; // Index after reset
    localparam logic LOCK_RST = 1'b0; // Lock after reset
    localparam logic WP_RST = 1'b1; // Write protect after reset
    localparam logic RP_RST = 1'b0; // Read protect after reset
    // ========================================
    // Read values
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00; // Unmapped offset
    localparam logic [7:0] BLOCKED_RDATA = 8'hff; // Inhibited read
    // Register byte layout
    typedef struct packed {
        logic [3:0] index; // Block index, bits 7-4
        logic idx_only; // Index-only write, bit 3
        logic lock; // Block lock, bit 2
        logic wp; // Write protect, bit 1
        logic rp; // Read protect, bit 0
    } xhbp_byte_t;
    // Memory access request
    typedef struct packed {
        logic req; // Access requested
        logic cs; // Chip select number
        logic write; // Write when high
        logic [ADDR_W-1:0] addr; // Byte address in chip select
    } xhbp_acc_t;
endpackage : xhbp_pkg

// file: xhbp_bank.sv
// Purpose: Index and per-block protection bits of one chip select
// Assumes: Serial-side write has priority over host write
// Notes: Readback is combinational; top registers it
`timescale 1ns/1ps
module xhbp_bank
    import xhbp_pkg::*;
#(
    parameter int NBLK = BLOCKS // Blocks held
)(
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Standby reset
    input wire logic lock_clr, // Clear all locks, level
    input wire logic host_wr, // Host write strobe
    input wire logic ec_wr, // Serial-side write strobe
    input wire xhbp_byte_t wdata, // Write byte
    output xhbp_byte_t view, // Readback byte
    output logic [NBLK-1:0] lock_vec, // Locks
    output logic [NBLK-1:0] wp_vec, // Write protects
    output logic [NBLK-1:0] rp_vec // Read protects
);
    logic [IDX_W-1:0] index_reg; // Current block index
    logic any_wr; // Either side writes
    assign any_wr = host_wr | ec_wr;
    // ========================================
    // Index field, always written
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            index_reg <= IDX_RST; // [R3]
        else if (any_wr)
            index_reg <= wdata.index; // [R3]
    end
    // ========================================
    // Per-block protection bits
    genvar k;
    generate
        for (k = 0; k < NBLK; k++)
        begin : g_blk
            logic hit; // Data write to this block
            assign hit = any_wr & ~wdata.idx_only & (wdata.index == IDX_W'(k)); // [R5] [R6]
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                begin
                    lock_vec[k] <= LOCK_RST; // [R9]
                    wp_vec[k] <= WP_RST; // [R13]
                    rp_vec[k] <= RP_RST; // [R14]
                end
                else if (lock_clr & lock_vec[k])
                begin
                    lock_vec[k] <= 1'b0; // [R9] [R10]
                    wp_vec[k] <= 1'b1; // [R12]
                    rp_vec[k] <= 1'b0; // [R12]
                end
                else if (hit & ec_wr)
                begin
                    // Serial side ignores the lock
                    lock_vec[k] <= wdata.lock; // [R11]
                    wp_vec[k] <= (lock_vec[k] & ~wdata.lock) | wdata.wp; // [R12]
                    rp_vec[k] <= ~(lock_vec[k] & ~wdata.lock) & wdata.rp; // [R12]
                end
                else if (hit & ~lock_vec[k])
                begin
                    lock_vec[k] <= wdata.lock; // [R8]
                    wp_vec[k] <= wdata.wp; // [R13]
                    rp_vec[k] <= wdata.rp; // [R14]
                end
            end
            // Cleared lock leaves block write protected
            property p_clr_prot;
                @(posedge ref_clk) disable iff (sys_rst)
                $fell(lock_vec[k]) |-> wp_vec[k] && !rp_vec[k];
            endproperty
            a_clr_prot: assert property (p_clr_prot) // [R12]
                else $error("cleared lock left block unprotected");
        end
    endgenerate
    // ========================================
    // Readback of the selected block
    assign view.index = index_reg; // [R2]
    assign view.idx_only = 1'b0; // [R7]
    assign view.lock = lock_vec[index_reg]; // [R2]
    assign view.wp = wp_vec[index_reg]; // [R2]
    assign view.rp = rp_vec[index_reg]; // [R2]
    // Index follows any write
    property p_index;
        @(posedge ref_clk) disable iff (sys_rst)
        any_wr |=> index_reg == $past(wdata.index);
    endproperty
    a_index: assert property (p_index) // [R3]
        else $error("index not updated by write");
endmodule : xhbp_bank

// file: xhbp_gate.sv
// Purpose: Decide whether a host memory access may proceed
// Assumes: Block size code per chip select, 0 = 16 KByte
// Notes: Purely combinational
`timescale 1ns/1ps
module xhbp_gate
    import xhbp_pkg::*;
(
    input wire xhbp_acc_t acc, // Host access request
    input wire logic [2:0] size_code, // Block size of selected cs
    input wire logic [BLOCKS-1:0] wp_vec, // Write protects of cs
    input wire logic [BLOCKS-1:0] rp_vec, // Read protects of cs
    output logic allow, // Access may go out
    output logic deny // Access inhibited
);
    logic [2:0] code_sat; // Size code clamped to 1 MByte
    logic [ADDR_W-1:0] shifted; // Address over block size
    logic [IDX_W-1:0] blk; // Addressed block
    logic prot; // Protection of that block
    // ========================================
    // Block number from block size
    assign code_sat = (size_code > MAX_SIZE_CODE) ? MAX_SIZE_CODE : size_code; // [R4]
    assign shifted = acc.addr >> (MIN_SHIFT + int'(code_sat)); // [R4]
    assign blk = shifted[IDX_W-1:0]; // [R4]
    // ========================================
    // Flag of the access direction
    assign prot = acc.write ? wp_vec[blk] : rp_vec[blk]; // [R13] [R14]
    assign allow = acc.req & ~prot; // [R15]
    assign deny = acc.req & prot; // [R15]
endmodule : xhbp_gate

// file: xhbp_top.sv
// Purpose: Host block protection for two peripheral chip selects
// Assumes: Register strobes, lock controls and access requests
//          come from logic on ref_clk
// Notes: Standby reset is sys_rst; main reset clears locks, setting write and clearing read protect of locked blocks, only when lock_reset_domain_select is 0
//
// Notes on behaviour
// [R1] Two protect registers, sixteen blocks each
// [R2] Three bits per block, reached via index
// [R3] Index bits 7-4, reset zero, picks block
// [R4] Block size from config, 16K to 1M
// [R5] Bit 3 set: only index is written
// [R6] Bit 3 clear: bits 2-0 to new block
// [R7] Bit 3 always reads back as zero
// [R8] Host lock sets only; locked bits frozen
// [R9] Lock cleared by selected reset domain
// [R10] Unlock request clears the lock
// [R11] Serial side writes lock freely
// [R12] Lock clear sets write, clears read protect
// [R13] Write protect blocks host writes, reset one
// [R14] Read protect blocks host reads, reset zero
// [R15] Inhibited access: no strobes, fixed read
`timescale 1ns/1ps
module xhbp_top
    import xhbp_pkg::*;
(
    input wire logic ref_clk, // 10 MHz clock
    input wire logic sys_rst, // Standby reset, sync, high
    input wire logic main_rst, // Main power or hw reset, high
    input wire logic lock_reset_domain_select, // 1: standby only
    input wire logic unlock_request, // Clear all locks, level
    input wire logic host_reg_wr, // Host register write
    input wire logic host_reg_rd, // Host register read
    input wire logic [7:0] host_reg_addr, // Host offset
    input wire logic [7:0] host_reg_wdata, // Host write data
    output logic [7:0] host_reg_rdata, // Host read data
    input wire logic ec_reg_wr, // Serial-side write
    input wire logic ec_reg_rd, // Serial-side read
    input wire logic [7:0] ec_reg_addr, // Serial-side offset
    input wire logic [7:0] ec_reg_wdata, // Serial-side data
    output logic [7:0] ec_reg_rdata, // Serial-side read data
    input wire xhbp_acc_t mem_acc, // Host memory access
    input wire logic [2:0] cs0_size_code, // Block size, cs 0
    input wire logic [2:0] cs1_size_code, // Block size, cs 1
    output logic chip_select_0, // Cs 0 enable, high active
    output logic chip_select_1, // Cs 1 enable, high active
    output logic mem_rd_strobe, // Read strobe enable
    output logic mem_wr_strobe, // Write strobe enable
    output logic mem_denied, // Access inhibited
    output logic [7:0] mem_blocked_rdata // Fixed read value
);

    // ========================================
    // Decode of both register ports
    logic host_cs0; // Host hits cs 0 reg
    logic host_cs1; // Host hits cs 1 reg
    logic ec_cs0; // Serial side hits cs 0 reg
    logic ec_cs1; // Serial side hits cs 1 reg
    assign host_cs0 = host_reg_addr == OFS_CS0; // [R1]
    assign host_cs1 = host_reg_addr == OFS_CS1; // [R1]
    assign ec_cs0 = ec_reg_addr == OFS_CS0; // [R1]
    assign ec_cs1 = ec_reg_addr == OFS_CS1; // [R1]
    // Write strobes per bank
    logic h_wr0; // Host write, cs 0
    logic h_wr1; // Host write, cs 1
    logic e_wr0; // Serial write, cs 0
    logic e_wr1; // Serial write, cs 1
    assign e_wr0 = ec_reg_wr & ec_cs0;
    assign e_wr1 = ec_reg_wr & ec_cs1;
    // Host write loses to a serial write of same bank
    assign h_wr0 = host_reg_wr & host_cs0 & ~e_wr0;
    assign h_wr1 = host_reg_wr & host_cs1 & ~e_wr1;
    // Byte selected per bank
    xhbp_byte_t wd0; // Write byte, cs 0
    xhbp_byte_t wd1; // Write byte, cs 1
    assign wd0 = e_wr0 ? xhbp_byte_t'(ec_reg_wdata) : xhbp_byte_t'(host_reg_wdata);
    assign wd1 = e_wr1 ? xhbp_byte_t'(ec_reg_wdata) : xhbp_byte_t'(host_reg_wdata);

    // ========================================
    // Lock clear sources
    logic lock_clr; // Clear every lock
    assign lock_clr = unlock_request | (main_rst & ~lock_reset_domain_select); // [R9] [R10]

    // ========================================
    // Banks for the two chip selects
    xhbp_byte_t view0; // Readback, cs 0
    xhbp_byte_t view1; // Readback, cs 1
    logic [BLOCKS-1:0] lock0; // Locks, cs 0
    logic [BLOCKS-1:0] lock1; // Locks, cs 1
    logic [BLOCKS-1:0] wp0; // Write protects, cs 0
    logic [BLOCKS-1:0] wp1; // Write protects, cs 1
    logic [BLOCKS-1:0] rp0; // Read protects, cs 0
    logic [BLOCKS-1:0] rp1; // Read protects, cs 1
    xhbp_bank #(.NBLK(BLOCKS)) u_bank0 ( // [R1]
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .lock_clr(lock_clr),
        .host_wr(h_wr0),
        .ec_wr(e_wr0),
        .wdata(wd0),
        .view(view0),
        .lock_vec(lock0),
        .wp_vec(wp0),
        .rp_vec(rp0)
    );
    xhbp_bank #(.NBLK(BLOCKS)) u_bank1 ( // [R1]
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .lock_clr(lock_clr),
        .host_wr(h_wr1),
        .ec_wr(e_wr1),
        .wdata(wd1),
        .view(view1),
        .lock_vec(lock1),
        .wp_vec(wp1),
        .rp_vec(rp1)
    );

    // ========================================
    // Read data selection
    logic [7:0] host_rsel; // Host readback
    logic [7:0] ec_rsel; // Serial readback
    assign host_rsel = host_cs0 ? view0 : (host_cs1 ? view1 : UNMAPPED_RDATA);
    assign ec_rsel = ec_cs0 ? view0 : (ec_cs1 ? view1 : UNMAPPED_RDATA);
    // Registered read data, one cycle after strobe
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            host_reg_rdata <= UNMAPPED_RDATA;
        else if (host_reg_rd)
            host_reg_rdata <= host_rsel; // [R7]
    end
    // Serial side read data
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ec_reg_rdata <= UNMAPPED_RDATA;
        else if (ec_reg_rd)
            ec_reg_rdata <= ec_rsel; // [R7]
    end

    // ========================================
    // Access gate on the addressed chip select
    logic [2:0] size_sel; // Size code of cs
    logic [BLOCKS-1:0] wp_sel; // Write protects of cs
    logic [BLOCKS-1:0] rp_sel; // Read protects of cs
    logic allow; // Access may go out
    assign size_sel = mem_acc.cs ? cs1_size_code : cs0_size_code;
    assign wp_sel = mem_acc.cs ? wp1 : wp0;
    assign rp_sel = mem_acc.cs ? rp1 : rp0;
    xhbp_gate u_gate (
        .acc(mem_acc),
        .size_code(size_sel),
        .wp_vec(wp_sel),
        .rp_vec(rp_sel),
        .allow(allow),
        .deny(mem_denied)
    );
    // Strobes only for allowed accesses
    assign chip_select_0 = allow & ~mem_acc.cs; // [R15]
    assign chip_select_1 = allow & mem_acc.cs; // [R15]
    assign mem_rd_strobe = allow & ~mem_acc.write; // [R15]
    assign mem_wr_strobe = allow & mem_acc.write; // [R15]
    // Fixed value for inhibited reads
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            mem_blocked_rdata <= BLOCKED_RDATA;
        else
            mem_blocked_rdata <= BLOCKED_RDATA; // [R15]
    end

    // ========================================
    // Checks
    // Bit 3 of host readback is always zero
    property p_rd_bit3;
        @(posedge ref_clk) disable iff (sys_rst)
        host_reg_rd |=> host_reg_rdata[3] == 1'b0;
    endproperty
    a_rd_bit3: assert property (p_rd_bit3) // [R7]
        else $error("index-only bit read back as one");

    // Bit 3 of serial readback is zero too
    property p_ec_bit3;
        @(posedge ref_clk) disable iff (sys_rst)
        ec_reg_rd |=> ec_reg_rdata[3] == 1'b0;
    endproperty
    a_ec_bit3: assert property (p_ec_bit3) // [R7]
        else $error("index-only bit read back as one on serial side");

    // Offsets outside the map read zero
    property p_unmapped;
        @(posedge ref_clk) disable iff (sys_rst)
        host_reg_rd && !host_cs0 && !host_cs1 |=> host_reg_rdata == UNMAPPED_RDATA;
    endproperty
    a_unmapped: assert property (p_unmapped) // [R1]
        else $error("unmapped offset read nonzero");

    // Index-only write leaves block bits alone
    property p_idx_only;
        @(posedge ref_clk) disable iff (sys_rst)
        h_wr0 && wd0.idx_only && !lock_clr |=> $stable(wp0) && $stable(rp0) && $stable(lock0);
    endproperty
    a_idx_only: assert property (p_idx_only) // [R5]
        else $error("index-only write changed block bits");

    // Locked cs 0 block ignores host writes
    property p_locked;
        @(posedge ref_clk) disable iff (sys_rst)
        h_wr0 && lock0[wd0.index] && !lock_clr
            |=> $stable(wp0) && $stable(rp0) && $stable(lock0);
    endproperty
    a_locked: assert property (p_locked) // [R8]
        else $error("host write changed a locked block");

    // Locked cs 1 block ignores host writes
    property p_locked1;
        @(posedge ref_clk) disable iff (sys_rst)
        h_wr1 && lock1[wd1.index] && !lock_clr
            |=> $stable(wp1) && $stable(rp1) && $stable(lock1);
    endproperty
    a_locked1: assert property (p_locked1) // [R8]
        else $error("host write changed a locked cs 1 block");

    // Data write lands in the newly indexed block
    property p_data_wr;
        @(posedge ref_clk) disable iff (sys_rst)
        h_wr0 && !wd0.idx_only && !lock0[wd0.index] && !lock_clr
            |=> wp0[$past(wd0.index)] == $past(wd0.wp);
    endproperty
    a_data_wr: assert property (p_data_wr) // [R6]
        else $error("data write not stored in new block");

    // Serial write sets the lock whatever its value
    property p_ec_lock;
        @(posedge ref_clk) disable iff (sys_rst)
        e_wr0 && !wd0.idx_only && !lock_clr |=> lock0[$past(wd0.index)] == $past(wd0.lock);
    endproperty
    a_ec_lock: assert property (p_ec_lock) // [R11]
        else $error("serial write did not set lock value");

    // Serial clear of a set lock restores protection
    property p_ec_clr;
        @(posedge ref_clk) disable iff (sys_rst)
        e_wr0 && !wd0.idx_only && !wd0.lock && lock0[wd0.index]
            |=> wp0[$past(wd0.index)] && !rp0[$past(wd0.index)];
    endproperty
    a_ec_clr: assert property (p_ec_clr) // [R12]
        else $error("serial lock clear left block unprotected");

    // Unlock request clears every lock
    property p_unlock;
        @(posedge ref_clk) disable iff (sys_rst)
        unlock_request && !host_reg_wr && !ec_reg_wr |=> lock0 == '0 && lock1 == '0;
    endproperty
    a_unlock: assert property (p_unlock) // [R10]
        else $error("unlock request left a lock set");

    // Main reset spares locks of the standby domain
    property p_main_rst;
        @(posedge ref_clk) disable iff (sys_rst)
        main_rst && lock_reset_domain_select && !unlock_request && !ec_reg_wr && !host_reg_wr
            |=> $stable(lock0);
    endproperty
    a_main_rst: assert property (p_main_rst) // [R9]
        else $error("main reset cleared standby-domain lock");

    // Main reset clears locks otherwise
    property p_main_clr;
        @(posedge ref_clk) disable iff (sys_rst)
        main_rst && !lock_reset_domain_select && !host_reg_wr && !ec_reg_wr
            |=> lock0 == '0 && lock1 == '0;
    endproperty
    a_main_clr: assert property (p_main_clr) // [R9]
        else $error("main reset left a lock set");

    // Denied write drives no select or strobe
    property p_deny_wr;
        @(posedge ref_clk) disable iff (sys_rst)
        mem_acc.req && mem_acc.write && mem_denied |-> !mem_wr_strobe && !chip_select_0
            && !chip_select_1;
    endproperty
    a_deny_wr: assert property (p_deny_wr) // [R13] [R15]
        else $error("strobes on inhibited write");

    // Denied read drives no select or strobe
    property p_deny_rd;
        @(posedge ref_clk) disable iff (sys_rst)
        mem_acc.req && !mem_acc.write && mem_denied
            |-> !mem_rd_strobe && !chip_select_0 && !chip_select_1;
    endproperty
    a_deny_rd: assert property (p_deny_rd) // [R14] [R15]
        else $error("strobes on inhibited read");

    // Reset values of the cs 0 bank
    property p_rst_prot;
        @(posedge ref_clk)
        sys_rst |=> wp0 == '1 && rp0 == '0 && lock0 == '0 && view0.index == IDX_RST;
    endproperty
    a_rst_prot: assert property (p_rst_prot) // [R13] [R14]
        else $error("reset values wrong");
endmodule : xhbp_top

// file: xhbp_host_model.sv
// Purpose: Register master model for the host and serial sides
// Assumes: Design takes strobes on the ref_clk rising edge
// Notes: Idle address and data lines show the inverse of the last value
`timescale 1ns/1ps
module xhbp_host_model
    import xhbp_pkg::*;
(
    input wire logic ref_clk, // Clock
    output logic host_reg_wr, // Host write strobe
    output logic host_reg_rd, // Host read strobe
    output logic [7:0] host_reg_addr, // Host offset
    output logic [7:0] host_reg_wdata, // Host write data
    input wire logic [7:0] host_reg_rdata, // Host read data
    output logic ec_reg_wr, // Serial write strobe
    output logic ec_reg_rd, // Serial read strobe
    output logic [7:0] ec_reg_addr, // Serial offset
    output logic [7:0] ec_reg_wdata, // Serial write data
    input wire logic [7:0] ec_reg_rdata // Serial read data
);
    // ========================================
    // Shared request state
    logic sel_ec = 1'b0; // Serial side selected
    logic wr_q = 1'b0; // Write pending
    logic rd_q = 1'b0; // Read pending
    logic [7:0] addr_q = 8'h00; // Offset lines
    logic [7:0] data_q = 8'h00; // Data lines
    // Steer strobes to the selected side
    assign host_reg_wr = wr_q & ~sel_ec;
    assign host_reg_rd = rd_q & ~sel_ec;
    assign ec_reg_wr = wr_q & sel_ec;
    assign ec_reg_rd = rd_q & sel_ec;
    assign host_reg_addr = addr_q;
    assign ec_reg_addr = addr_q;
    assign host_reg_wdata = data_q;
    assign ec_reg_wdata = data_q;
    // ========================================
    // One register cycle, held across its taking edge
    task automatic access(input logic ec, input logic wr, input logic [7:0] addr,
        input logic [7:0] data, output logic [7:0] rdata);
        @(negedge ref_clk);
        sel_ec = ec;
        addr_q = addr;
        data_q = data;
        wr_q = wr;
        rd_q = ~wr;
        @(posedge ref_clk);
        @(negedge ref_clk);
        // Release; lines no longer carry the old value
        wr_q = 1'b0;
        rd_q = 1'b0;
        addr_q = ~addr;
        data_q = ~data;
        rdata = ec ? ec_reg_rdata : host_reg_rdata;
    endtask : access
endmodule : xhbp_host_model

// file: xhbp_top_tb.sv
// Purpose: Self-checking bench for host block protection
// Assumes: Register cycles come from the host model
// Notes: cs0 uses 16 KByte blocks, cs1 uses 1 MByte blocks
`timescale 1ns/1ps
module xhbp_top_tb;
    import xhbp_pkg::*;
    // ========================================
    // Signals
    logic ref_clk = 1'b0; // Clock
    logic sys_rst = 1'b1; // Standby reset
    logic main_rst = 1'b0; // Main reset
    logic lock_reset_domain_select = 1'b0; // Lock reset domain
    logic unlock_request = 1'b0; // Unlock level
    logic host_reg_wr, host_reg_rd, ec_reg_wr, ec_reg_rd; // Strobes
    logic [7:0] host_reg_addr, host_reg_wdata, host_reg_rdata; // Host bus
    logic [7:0] ec_reg_addr, ec_reg_wdata, ec_reg_rdata; // Serial bus
    xhbp_acc_t mem_acc = '0; // Memory access
    logic [2:0] cs0_size_code = 3'h0; // 16 KByte blocks
    logic [2:0] cs1_size_code = 3'h6; // 1 MByte blocks
    logic chip_select_0, chip_select_1, mem_rd_strobe, mem_wr_strobe, mem_denied;
    logic [7:0] mem_blocked_rdata; // Fixed read value
    logic [7:0] rv; // Read value
    int errors = 0; // Mismatches
    int checks_done = 0; // Comparisons
    // Row: side, offset, write data, readback expected
    typedef struct packed {logic ec; logic [7:0] addr; logic [7:0] data;
        logic [7:0] exp;} xhbp_row_t;
    localparam xhbp_row_t ROWS [0:9] = '{
        '{1'b0, 8'h13, 8'h50, 8'h50}, '{1'b0, 8'h13, 8'h38, 8'h32},
        '{1'b0, 8'h13, 8'h5f, 8'h50}, '{1'b0, 8'h13, 8'h57, 8'h57},
        '{1'b0, 8'h13, 8'h50, 8'h57}, '{1'b1, 8'h13, 8'h50, 8'h52},
        '{1'b0, 8'h14, 8'hf1, 8'hf1}, '{1'b0, 8'h13, 8'h00, 8'h00},
        '{1'b0, 8'h12, 8'hff, 8'h00}, '{1'b1, 8'h14, 8'hf5, 8'hf5}};
    // ========================================
    // Clock, 100 ns period
    always #50 ref_clk = ~ref_clk;
    // ========================================
    // Instances
    xhbp_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .main_rst(main_rst),
        .lock_reset_domain_select(lock_reset_domain_select),
        .unlock_request(unlock_request), .host_reg_wr(host_reg_wr),
        .host_reg_rd(host_reg_rd), .host_reg_addr(host_reg_addr),
        .host_reg_wdata(host_reg_wdata), .host_reg_rdata(host_reg_rdata),
        .ec_reg_wr(ec_reg_wr), .ec_reg_rd(ec_reg_rd), .ec_reg_addr(ec_reg_addr),
        .ec_reg_wdata(ec_reg_wdata), .ec_reg_rdata(ec_reg_rdata), .mem_acc(mem_acc),
        .cs0_size_code(cs0_size_code), .cs1_size_code(cs1_size_code),
        .chip_select_0(chip_select_0), .chip_select_1(chip_select_1),
        .mem_rd_strobe(mem_rd_strobe), .mem_wr_strobe(mem_wr_strobe),
        .mem_denied(mem_denied), .mem_blocked_rdata(mem_blocked_rdata));
    xhbp_host_model u_host (.ref_clk(ref_clk), .host_reg_wr(host_reg_wr),
        .host_reg_rd(host_reg_rd), .host_reg_addr(host_reg_addr),
        .host_reg_wdata(host_reg_wdata), .host_reg_rdata(host_reg_rdata),
        .ec_reg_wr(ec_reg_wr), .ec_reg_rd(ec_reg_rd), .ec_reg_addr(ec_reg_addr),
        .ec_reg_wdata(ec_reg_wdata), .ec_reg_rdata(ec_reg_rdata));
    // ========================================
    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Host read of one offset
    task automatic rd(input logic [7:0] addr);
        u_host.access(1'b0, 1'b0, addr, 8'h00, rv);
    endtask : rd
    // One memory access; allowed gives selects and strobe, else deny only
    task automatic mem(input logic cs, input logic wr, input logic [23:0] addr, input logic ok);
        @(negedge ref_clk);
        mem_acc = '{1'b1, cs, wr, addr};
        #10;
        check("mem", {3'h0, chip_select_0, chip_select_1, mem_rd_strobe, mem_wr_strobe,
            mem_denied}, ok ? {3'h0, ~cs, cs, ~wr, wr, 1'b0} : 8'h01);
        // Hold the access across the next rising edge
        @(negedge ref_clk);
        mem_acc.req = 1'b0;
    endtask : mem
    // One-cycle pulse on a control level
    task automatic pulse(input int which);
        @(negedge ref_clk);
        if (which == 0) unlock_request = 1'b1; else if (which == 1) main_rst = 1'b1;
        else sys_rst = 1'b1;
        @(negedge ref_clk);
        unlock_request = 1'b0;
        main_rst = 1'b0;
        sys_rst = 1'b0;
    endtask : pulse
    // ========================================
    // Verdict and end of run
    task automatic conclude();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // Watchdog well beyond the expected length
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        errors++;
        conclude();
    end
    // ========================================
    // Main sequence
    initial
    begin
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        rd(8'h14);
        check("reset cs1", rv, 8'h02);
        // Table: write then read back through the host
        for (int i = 0; i < 10; i++)
        begin
            u_host.access(ROWS[i].ec, 1'b1, ROWS[i].addr, ROWS[i].data, rv);
            rd(ROWS[i].addr);
            check("row", rv, ROWS[i].exp);
        end
        u_host.access(1'b1, 1'b0, 8'h14, 8'h00, rv);
        check("serial read", rv, 8'hf5);
        // Host cannot touch the locked cs 1 block
        u_host.access(1'b0, 1'b1, 8'h14, 8'hf1, rv);
        rd(8'h14);
        check("cs1 locked", rv, 8'hf5);
        // Serial clear forces write protect on, read protect off
        u_host.access(1'b1, 1'b1, 8'h14, 8'hf1, rv);
        rd(8'h14);
        check("serial clear", rv, 8'hf2);
        u_host.access(1'b0, 1'b1, 8'h14, 8'hf1, rv);
        // Memory gating by block and direction
        mem(1'b0, 1'b1, 24'h000000, 1'b1);
        mem(1'b0, 1'b1, 24'h014000, 1'b0);
        mem(1'b0, 1'b0, 24'h017fff, 1'b1);
        mem(1'b1, 1'b0, 24'hf00000, 1'b0);
        mem(1'b1, 1'b1, 24'hffffff, 1'b1);
        mem(1'b1, 1'b0, 24'he00000, 1'b1);
        // Size codes above 1 MByte clamp to it
        cs1_size_code = 3'h7;
        mem(1'b1, 1'b0, 24'hf00000, 1'b0);
        check("blocked data", mem_blocked_rdata, BLOCKED_RDATA);
        // Unlock request clears a host lock
        u_host.access(1'b0, 1'b1, 8'h13, 8'h54, rv);
        pulse(0);
        rd(8'h13);
        check("unlock", rv, 8'h52);
        // Main reset honours the lock domain
        u_host.access(1'b0, 1'b1, 8'h13, 8'h55, rv);
        lock_reset_domain_select = 1'b1;
        pulse(1);
        rd(8'h13);
        check("main kept", rv, 8'h55);
        lock_reset_domain_select = 1'b0;
        pulse(1);
        rd(8'h13);
        check("main clr", rv, 8'h52);
        // Standby reset in mid-run
        u_host.access(1'b0, 1'b1, 8'h13, 8'h55, rv);
        pulse(2);
        rd(8'h13);
        check("rst cs0", rv, 8'h02);
        rd(8'h14);
        check("rst cs1", rv, 8'h02);
        conclude();
    end
endmodule : xhbp_top_tb
